// ### core/timer_support.sv
// Prescaler, channel filter, transfer window, trigger and interrupt registers.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`include "timer_support_map.svh"
module timer_support
#(
   parameter int CHANNELS = 3
)
(
   input  wire logic                   i_clk,
   input  wire logic                   i_sys_rst,
   input  wire logic [7:0]             i_addr,
   input  wire logic [31:0]            i_wdata,
   input  wire logic                   i_wr,
   input  wire logic                   i_rd,
   output logic [31:0]                 o_rdata,
   input  wire logic                   i_tick_source,
   input  wire logic                   i_debug_halt,
   input  wire logic [CHANNELS-1:0]    i_channel,
   input  wire logic [CHANNELS-1:0]    i_capture_mode,
   input  wire logic                   i_fault,
   input  wire logic                   i_index_pulse,
   input  wire logic [15:0]            i_target,
   input  wire logic                   i_count_up,
   input  wire logic                   i_double_transition,
   input  wire logic [CHANNELS-1:0]    i_channel_event,
   output timer_support_pkg::operating_mode_type o_operating_mode,
   output logic [15:0]                 o_main_counter,
   output logic                        o_counter_step,
   output logic                        o_prescaler_event,
   output logic [CHANNELS-1:0]         o_filtered,
   output logic                        o_edge_flush,
   output logic                        o_transfer_request,
   output logic                        o_converter_trigger
);
   import timer_support_pkg::*;

   function automatic logic [`IRQ_WIDTH-1:0] pick(
      input logic [`IRQ_WIDTH-1:0] v, input logic [`SEL_WIDTH-1:0] s);
      pick = (s == 4'h0 || s > 4'hb) ? '0 : (`IRQ_WIDTH'(1) << (s - 4'h1));
      pick = pick & v;
   endfunction : pick

   logic [31:0]            prescaler_config_reg;
   logic [7:0]             prescaler_event_reg;
   logic [7:0]             input_filter_reg;
   logic [31:0]            transfer_config_reg;
   logic [3:0]             converter_trigger_reg;
   logic [31:0]            output_override_reg;
   logic                   debug_freeze_reg;
   operating_mode_type     mode_reg;
   logic [`IRQ_WIDTH-1:0]  irq_mask_reg;
   logic [`IRQ_WIDTH-1:0]  irq_raw_reg;
   logic [`IRQ_WIDTH-1:0]  irq_raw_next;
   logic [7:0]             prescaler_reg;
   logic [15:0]            counter_reg;
   logic                   count_up_reg;
   logic [1:0]             tick_sync_reg;
   logic                   tick_last_reg;
   logic [1:0]             halt_sync_reg;
   logic [1:0]             fault_sync_reg;
   logic [1:0]             index_sync_reg;
   logic [CHANNELS-1:0]    ch_meta_reg;
   logic [CHANNELS-1:0]    ch_sync_reg;
   logic [CHANNELS-1:0]    ch_last_reg;
   logic [CHANNELS-1:0]    filtered_reg;
   logic [7:0]             filt_cnt_reg [CHANNELS];
   logic [7:0]             pointer_reg;
   logic [7:0]             remaining_reg;
   logic [31:0]            rdata_reg;
   logic                   step_reg;
   logic                   pre_event_reg;
   logic                   xfer_req_reg;
   logic                   conv_trig_reg;
   freeze_state_type       freeze_state_reg;
   logic [1:0]             flush_cnt_reg;

   wire                    frozen     = freeze_state_reg != run_state;
   wire                    running    = mode_reg != mode_disabled;
   wire                    tick_rise  = tick_sync_reg[1] & ~tick_last_reg;
   wire                    pre_zero   = prescaler_reg == 8'h00;
   wire                    step       = running & ~frozen & tick_rise
                                        & pre_zero;
   wire [7:0]              tick_div   = prescaler_config_reg[15:8];
   wire [7:0]              start_word = transfer_config_reg[15:8];
   wire [7:0]              word_count = transfer_config_reg[23:16];
   wire [3:0]              req_select = transfer_config_reg[3:0];
   wire                    win_live   = remaining_reg != 8'h00;
   wire                    win_wr     = i_wr & (i_addr ==
                                        `OFS_TRANSFER_WINDOW);
   wire                    win_rd     = i_rd & (i_addr ==
                                        `OFS_TRANSFER_WINDOW);
   wire                    win_hit    = (win_wr | win_rd) & win_live;
   wire [7:0]              eff_addr   = win_hit ? pointer_reg : i_addr;
   wire                    eff_wr     = win_wr ? win_hit : i_wr;
   wire                    eff_rd     = win_rd ? win_hit : i_rd;
   wire                    wr_set     = eff_wr & (eff_addr ==
                                        `OFS_IRQ_FORCE_SET);
   wire                    wr_clr     = eff_wr & (eff_addr ==
                                        `OFS_IRQ_CLEAR);
   wire [15:0]             count_next = count_up_reg ? counter_reg + 16'h1
                                        : counter_reg - 16'h1;
   wire                    dir_flip   = step & (i_count_up != count_up_reg);
   wire [`IRQ_WIDTH-1:0]   hw_events;
   wire [`IRQ_WIDTH-1:0]   new_set    = hw_events | (wr_set ?
                                        i_wdata[`IRQ_WIDTH-1:0] : '0);
   wire [`IRQ_WIDTH-1:0]   rise       = irq_raw_next & ~irq_raw_reg;
   wire [`IRQ_WIDTH-1:0]   masked     = irq_raw_reg & irq_mask_reg;
   wire                    req_hit    = |pick(rise, req_select);
   wire [31:0]             read_mux;

   assign hw_events[`BIT_TARGET_MATCH]      = step &
                                             (count_next == i_target);
   assign hw_events[`BIT_ZERO]              = step & (count_next == 16'h0);
   assign hw_events[`BIT_DOUBLE_TRANSITION] = ~frozen & i_double_transition
                                             & (mode_reg == mode_quadrature);
   assign hw_events[`BIT_COUNT_CHANGE]      = step;
   assign hw_events[`BIT_DIRECTION_CHANGE]  = dir_flip;
   assign hw_events[`BIT_INDEX_PULSE]       = index_sync_reg[1];
   assign hw_events[`BIT_FAULT]             = fault_sync_reg[1];
   assign hw_events[7]                      = 1'b0;
   assign hw_events[`IRQ_WIDTH-1:`BIT_CHANNEL0] = frozen ? '0
                                             : i_channel_event;

   // Sets are ORed after the clear so an event is never lost.
   assign irq_raw_next = ((irq_raw_reg & ~(wr_clr ?
                         i_wdata[`IRQ_WIDTH-1:0] : '0))
                         | new_set) & `IRQ_VALID_MASK;

   assign read_mux =
      (eff_addr == `OFS_PRESCALER_CONFIG)  ? prescaler_config_reg :
      (eff_addr == `OFS_PRESCALER_EVENT)   ? {24'h0, prescaler_event_reg} :
      (eff_addr == `OFS_INPUT_FILTER)      ? {24'h0, input_filter_reg} :
      (eff_addr == `OFS_QUADRATURE_STATUS) ? {31'h0, count_up_reg} :
      (eff_addr == `OFS_TRANSFER_CONFIG)   ? transfer_config_reg :
      (eff_addr == `OFS_CONVERTER_TRIGGER) ? {28'h0, converter_trigger_reg} :
      (eff_addr == `OFS_OUTPUT_OVERRIDE)   ? output_override_reg :
      (eff_addr == `OFS_IRQ_MASK)          ? {21'h0, irq_mask_reg} :
      (eff_addr == `OFS_IRQ_RAW_STATUS)    ? {21'h0, irq_raw_reg} :
      (eff_addr == `OFS_IRQ_MASKED_STATUS) ? {21'h0, masked} :
      (eff_addr == `OFS_DEBUG_FREEZE)      ? {31'h0, debug_freeze_reg} :
      (eff_addr == `OFS_MODE_CONTROL)      ? {30'h0, mode_reg} :
                                             `RESET_WORD;

   assign o_rdata             = rdata_reg;
   assign o_operating_mode    = mode_reg;
   assign o_main_counter      = counter_reg;
   assign o_counter_step      = step_reg;
   assign o_prescaler_event   = pre_event_reg;
   assign o_filtered          = filtered_reg;
   assign o_edge_flush        = freeze_state_reg == flush_state;
   assign o_transfer_request  = xfer_req_reg;
   assign o_converter_trigger = conv_trig_reg;

   always_ff @(posedge i_clk)
   begin
      tick_sync_reg  <= {tick_sync_reg[0], i_tick_source};
      halt_sync_reg  <= {halt_sync_reg[0], i_debug_halt};
      fault_sync_reg <= {fault_sync_reg[0], i_fault};
      index_sync_reg <= {index_sync_reg[0], i_index_pulse};
      ch_meta_reg    <= i_channel;
      ch_sync_reg    <= ch_meta_reg;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         prescaler_config_reg  <= `RESET_WORD;
         prescaler_event_reg   <= 8'h00;
         input_filter_reg      <= 8'h00;
         transfer_config_reg   <= `RESET_WORD;
         converter_trigger_reg <= 4'h0;
         output_override_reg   <= `RESET_WORD;
         debug_freeze_reg      <= 1'b0;
         mode_reg              <= mode_disabled;
         irq_mask_reg          <= '0;
         irq_raw_reg           <= '0;
         rdata_reg             <= `RESET_WORD;
      end
      else
      begin
         irq_raw_reg <= irq_raw_next;
         rdata_reg   <= eff_rd ? read_mux : `RESET_WORD;
         if (eff_wr)
         begin
            case (eff_addr)
               `OFS_PRESCALER_CONFIG:  prescaler_config_reg <= i_wdata;
               `OFS_PRESCALER_EVENT:   prescaler_event_reg <= i_wdata[7:0];
               `OFS_INPUT_FILTER:      input_filter_reg <= i_wdata[7:0];
               `OFS_TRANSFER_CONFIG:   transfer_config_reg <= i_wdata;
               `OFS_CONVERTER_TRIGGER: converter_trigger_reg <= i_wdata[3:0];
               `OFS_OUTPUT_OVERRIDE:   output_override_reg <= i_wdata;
               `OFS_DEBUG_FREEZE:      debug_freeze_reg <= i_wdata[0];
               `OFS_MODE_CONTROL:      mode_reg <=
                                          operating_mode_type'(i_wdata[1:0]);
               `OFS_IRQ_MASK:          irq_mask_reg <= i_wdata[`IRQ_WIDTH-1:0]
                                          & `IRQ_VALID_MASK;
               `OFS_IRQ_MASK_SET:      irq_mask_reg <= irq_mask_reg
                                          | (i_wdata[`IRQ_WIDTH-1:0]
                                          & `IRQ_VALID_MASK);
               `OFS_IRQ_MASK_CLEAR:    irq_mask_reg <= irq_mask_reg
                                          & ~i_wdata[`IRQ_WIDTH-1:0];
               default:                ;
            endcase
         end
      end
   end

   // Freeze follows halt; on release the filters flush for two cycles.
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         freeze_state_reg <= run_state;
         flush_cnt_reg    <= 2'h0;
      end
      else
      begin
         case (freeze_state_reg)
            run_state:
               if (debug_freeze_reg & halt_sync_reg[1])
                  freeze_state_reg <= frozen_state;
            frozen_state:
               if (~(debug_freeze_reg & halt_sync_reg[1]))
               begin
                  freeze_state_reg <= flush_state;
                  flush_cnt_reg    <= `FLUSH_CYCLES;
               end
            flush_state:
            begin
               flush_cnt_reg <= flush_cnt_reg - 2'h1;
               if (flush_cnt_reg == 2'h1)
                  freeze_state_reg <= run_state;
            end
            default: freeze_state_reg <= run_state;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         tick_last_reg <= 1'b0;
         prescaler_reg <= 8'h00;
         counter_reg   <= 16'h0;
         count_up_reg  <= 1'b0;
         step_reg      <= 1'b0;
         pre_event_reg <= 1'b0;
      end
      else
      begin
         tick_last_reg <= tick_sync_reg[1];
         step_reg      <= step;
         if (!running)
            prescaler_reg <= tick_div;
         else if (tick_rise & ~frozen)
            prescaler_reg <= pre_zero ? tick_div
                             : prescaler_reg - 8'h01;
         if (step)
         begin
            counter_reg  <= count_next;
            count_up_reg <= i_count_up;
         end
         if (!frozen)
            pre_event_reg <= running & (prescaler_reg != 8'h00)
                             & (prescaler_reg <= prescaler_event_reg);
      end
   end

   genvar c;
   generate
      for (c = 0; c < CHANNELS; c++)
      begin : g_filter
         always_ff @(posedge i_clk)
         begin
            if (i_sys_rst | o_edge_flush)
            begin
               ch_last_reg[c]  <= 1'b0;
               filt_cnt_reg[c] <= 8'h00;
               filtered_reg[c] <= 1'b0;
            end
            else if (!frozen)
            begin
               ch_last_reg[c] <= ch_sync_reg[c];
               if (!i_capture_mode[c])
                  filtered_reg[c] <= ch_sync_reg[c];
               else if (ch_sync_reg[c] != ch_last_reg[c])
               begin
                  filt_cnt_reg[c] <= input_filter_reg;
                  if (input_filter_reg == 8'h00)
                     filtered_reg[c] <= ch_sync_reg[c];
               end
               else if (filt_cnt_reg[c] > 8'h01)
                  filt_cnt_reg[c] <= filt_cnt_reg[c] - 8'h01;
               else
               begin
                  filt_cnt_reg[c] <= 8'h00;
                  filtered_reg[c] <= ch_sync_reg[c];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         pointer_reg   <= 8'h00;
         remaining_reg <= 8'h00;
         xfer_req_reg  <= 1'b0;
         conv_trig_reg <= 1'b0;
      end
      else
      begin
         xfer_req_reg  <= req_hit;
         conv_trig_reg <= |pick(rise, converter_trigger_reg);
         if (req_hit)
         begin
            pointer_reg   <= {start_word[5:0], 2'b00};
            remaining_reg <= word_count;
         end
         else if (win_hit)
         begin
            pointer_reg   <= pointer_reg + `WORD_STEP;
            remaining_reg <= remaining_reg - 8'h01;
         end
      end
   end

   sequence seq_set_write;
      wr_set & ~wr_clr;
   endsequence

   default clocking cb_sys @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   chk_masked_and: assert property (
      ($past(eff_rd) && ($past(eff_addr) == `OFS_IRQ_MASKED_STATUS)) |->
      (o_rdata == {21'h0, $past(irq_raw_reg) & $past(irq_mask_reg)}))
      else $error("Masked status read differs from raw and mask.");
   chk_reserved_zero: assert property (
      ($past(eff_rd) && ($past(eff_addr) == `OFS_IRQ_RAW_STATUS)) |->
      ((o_rdata[31:11] == 21'h0) && (o_rdata[7] == 1'b0)))
      else $error("Reserved status bit reads as one.");
   chk_force_set: assert property (
      seq_set_write |=> ((irq_raw_reg & $past(i_wdata[`IRQ_WIDTH-1:0])
      & `IRQ_VALID_MASK) == ($past(i_wdata[`IRQ_WIDTH-1:0])
      & `IRQ_VALID_MASK)))
      else $error("Force set did not raise flags.");
   chk_event_wins: assert property (
      (wr_clr & step) |=> irq_raw_reg[`BIT_COUNT_CHANGE])
      else $error("Clear beat a hardware event.");
   chk_fault_flag: assert property (
      fault_sync_reg[1] |=> irq_raw_reg[`BIT_FAULT])
      else $error("Fault flag not set.");
   chk_step_rate: assert property (
      !$stable(counter_reg) |-> $past(step))
      else $error("Counter moved without a prescaler step.");
   chk_window_stop: assert property (
      (win_wr & ~win_live & ~req_hit) |=> $stable(pointer_reg))
      else $error("Pointer moved after word count.");
   chk_frozen_hold: assert property (
      frozen |=> $stable(counter_reg))
      else $error("Counter moved while frozen.");
   chk_flush_len: assert property (
      $rose(o_edge_flush) |-> o_edge_flush[*2] ##1 !o_edge_flush)
      else $error("Flush not two cycles.");
endmodule : timer_support

// ### pkg/timer_support_map.svh
// Register offsets, field positions, reset values and counts of the timer support block.
`ifndef TIMER_SUPPORT_MAP_SVH
`define TIMER_SUPPORT_MAP_SVH
`define OFS_PRESCALER_CONFIG   8'h18
`define OFS_PRESCALER_EVENT    8'h1c
`define OFS_INPUT_FILTER       8'h20
`define OFS_QUADRATURE_STATUS  8'h34
`define OFS_TRANSFER_CONFIG    8'h3c
`define OFS_TRANSFER_WINDOW    8'h40
`define OFS_CONVERTER_TRIGGER  8'h44
`define OFS_OUTPUT_OVERRIDE    8'h48
`define OFS_IRQ_MASK           8'h68
`define OFS_IRQ_RAW_STATUS     8'h6c
`define OFS_IRQ_MASKED_STATUS  8'h70
`define OFS_IRQ_FORCE_SET      8'h74
`define OFS_IRQ_CLEAR          8'h78
`define OFS_IRQ_MASK_SET       8'h7c
`define OFS_IRQ_MASK_CLEAR     8'h80
`define OFS_DEBUG_FREEZE       8'h84
`define OFS_MODE_CONTROL       8'h0c
`define RESET_WORD             32'h00000000
`define IRQ_VALID_MASK         11'h77f
`define BIT_TARGET_MATCH       0
`define BIT_ZERO               1
`define BIT_DOUBLE_TRANSITION  2
`define BIT_COUNT_CHANGE       3
`define BIT_DIRECTION_CHANGE   4
`define BIT_INDEX_PULSE        5
`define BIT_FAULT              6
`define BIT_CHANNEL0           8
`define IRQ_WIDTH              11
`define SEL_WIDTH              4
`define WORD_STEP              8'h04
`define FLUSH_CYCLES           2'h2
`endif

// ### pkg/timer_support_pkg.sv
// Types shared by the timer support block.
package timer_support_pkg;
   typedef enum logic [1:0] {
      mode_disabled,
      mode_up,
      mode_updown,
      mode_quadrature
   } operating_mode_type;
   typedef enum {
      run_state,
      frozen_state,
      flush_state
   } freeze_state_type;
endpackage : timer_support_pkg

// ### tb/bus_host_model.sv
// Register bus host standing in for the processor and the transfer engine.
`timescale 1ns/10ps
module bus_host_model
(
   input  wire logic        i_clk,
   output logic [7:0]       o_addr,
   output logic [31:0]      o_wdata,
   output logic             o_wr,
   output logic             o_rd,
   input  wire logic [31:0] i_rdata
);
   initial
   begin
      o_addr = 8'h00;
      o_wdata = 32'h00000000;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   // Write data are inverted once released so stale values cannot match.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_wdata <= ~d;
   endtask : wr
   // Read data are taken in the one cycle after the strobe.
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      @(posedge i_clk);
      d = i_rdata;
   endtask : rd
endmodule : bus_host_model

// ### tb/testbench.sv
// Self-checking bench of the timer support block.
`timescale 1ns/10ps
module testbench;
   import timer_support_pkg::*;
   localparam logic [31:0] all_bits = 32'hffffffff;
   localparam logic [31:0] hw_bits  = 32'hffffffe4;
   logic        i_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, val;
   logic        wr, rd, step, pre_ev, flush, xfer, trig;
   logic        halt = 1'b0, fault = 1'b0, index = 1'b0, dbl = 1'b0;
   logic [2:0]  chan = 3'h0, capture = 3'h0, chev = 3'h0, filt;
   logic [2:0]  filt_seen = 3'h0;
   logic [1:0]  tick_cnt = 2'h0;
   logic        tick_on = 1'b0;
   operating_mode_type mode;
   logic [15:0] counter;
   int          n_step = 0, n_pre = 0, n_flush = 0, n_xfer = 0, n_trig = 0;
   int          error_cnt = 0;
   int          n_compared = 0;
   always #20 i_clk = ~i_clk;
   bus_host_model host (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata),
      .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
   timer_support dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_tick_source(tick_cnt[1]), .i_debug_halt(halt), .i_channel(chan),
      .i_capture_mode(capture), .i_fault(fault), .i_index_pulse(index),
      .i_target(16'hffff), .i_count_up(1'b0), .i_double_transition(dbl),
      .i_channel_event(chev), .o_operating_mode(mode),
      .o_main_counter(counter), .o_counter_step(step),
      .o_prescaler_event(pre_ev), .o_filtered(filt), .o_edge_flush(flush),
      .o_transfer_request(xfer), .o_converter_trigger(trig));
   // Tick source with a period of four clocks, and output tallies.
   always @(posedge i_clk)
   begin
      if (tick_on)
         tick_cnt <= tick_cnt + 2'h1;
      n_step <= n_step + (step === 1'b1);
      n_pre <= n_pre + (pre_ev === 1'b1);
      n_flush <= n_flush + (flush === 1'b1);
      n_xfer <= n_xfer + (xfer === 1'b1);
      n_trig <= n_trig + (trig === 1'b1);
      filt_seen <= filt_seen | filt;
   end
   task automatic stop_test();
      if (error_cnt == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
      host.rd(a, val);
      chk(val & m, e);
   endtask : rchk
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask : cyc
   task automatic scen_reset();
      logic [7:0] ofs [16] = '{8'h18, 8'h1c, 8'h20, 8'h34, 8'h3c, 8'h40,
         8'h44, 8'h48, 8'h68, 8'h70, 8'h74, 8'h78, 8'h7c, 8'h80, 8'h84, 8'hfc};
      foreach (ofs[i])
         rchk(ofs[i], all_bits, 32'h0);
      rchk(8'h6c, hw_bits, 32'h0);
   endtask : scen_reset
   task automatic scen_flags();
      host.wr(8'h74, all_bits);
      rchk(8'h6c, all_bits, 32'h0000077f);
      host.wr(8'h7c, 32'h0000000f);
      host.wr(8'h7c, 32'h00000100);
      rchk(8'h70, all_bits, 32'h0000010f);
      host.wr(8'h80, 32'h00000003);
      rchk(8'h68, all_bits, 32'h0000010c);
      rchk(8'h70, all_bits, 32'h0000010c);
      host.wr(8'h6c, 32'h0);
      host.wr(8'h78, 32'h00000104);
      rchk(8'h6c, hw_bits, 32'h00000660);
      host.wr(8'h78, all_bits);
      host.wr(8'h80, all_bits);
   endtask : scen_flags
   task automatic scen_inputs();
      host.wr(8'h0c, 32'h00000003);
      fault <= 1'b1;
      index <= 1'b1;
      dbl <= 1'b1;
      chev <= 3'h7;
      cyc(1);
      dbl <= 1'b0;
      chev <= 3'h0;
      host.wr(8'h78, 32'h00000060);
      cyc(4);
      rchk(8'h6c, hw_bits, 32'h00000764);
      fault <= 1'b0;
      index <= 1'b0;
      cyc(4);
      host.wr(8'h78, all_bits);
      rchk(8'h6c, hw_bits, 32'h0);
      host.wr(8'h0c, 32'h00000000);
   endtask : scen_inputs
   task automatic scen_transfer();
      int x0, t0;
      host.wr(8'h44, 32'h00000009);
      host.wr(8'h3c, 32'h00021a09);
      @(negedge i_clk);
      x0 = n_xfer;
      t0 = n_trig;
      host.wr(8'h74, 32'h00000100);
      host.wr(8'h74, 32'h00000140);
      cyc(3);
      @(negedge i_clk);
      chk(n_xfer - x0, 1);
      chk(n_trig - t0, 1);
      host.wr(8'h40, 32'h0000000f);
      rchk(8'h40, 32'h00000100, 32'h00000100);
      rchk(8'h40, all_bits, 32'h0);
      host.wr(8'h40, 32'h00000000);
      rchk(8'h68, all_bits, 32'h0000000f);
      host.wr(8'h3c, 32'h0);
      host.wr(8'h44, 32'h0);
      host.wr(8'h78, all_bits);
      host.wr(8'h80, all_bits);
   endtask : scen_transfer
   task automatic scen_filter();
      host.wr(8'h20, 32'h00000003);
      capture <= 3'h7;
      host.wr(8'h0c, 32'h00000001);
      cyc(8);
      chk(mode, 32'h1);
      @(negedge i_clk);
      filt_seen = 3'h0;
      cyc(1);
      chan <= 3'h7;
      cyc(3);
      chan <= 3'h0;
      cyc(10);
      @(negedge i_clk);
      chk(filt_seen, 32'h0);
      cyc(1);
      chan <= 3'h7;
      cyc(4);
      chan <= 3'h0;
      cyc(12);
      @(negedge i_clk);
      chk(filt_seen, 32'h7);
      chk(filt, 32'h0);
   endtask : scen_filter
   task automatic scen_prescale();
      int s0, p0;
      logic [15:0] c0;
      host.wr(8'h18, 32'h00000300);
      host.wr(8'h1c, 32'h00000001);
      @(negedge i_clk);
      c0 = counter;
      cyc(20);
      chk(counter, c0);
      tick_on <= 1'b1;
      repeat (8) host.wr(8'h78, 32'h00000008);
      cyc(1);
      repeat (8) host.wr(8'h78, 32'h00000008);
      cyc(7);
      @(negedge i_clk);
      s0 = n_step;
      p0 = n_pre;
      c0 = counter;
      cyc(64);
      @(negedge i_clk);
      chk(n_step - s0, 4);
      chk(16'(c0 - counter), 32'h4);
      chk(n_pre - p0, 16);
      rchk(8'h6c, 32'h0000001b, 32'h00000009);
   endtask : scen_prescale
   task automatic scen_freeze();
      int s0, f0;
      logic [15:0] c0;
      host.wr(8'h84, 32'h00000001);
      halt <= 1'b1;
      cyc(6);
      @(negedge i_clk);
      c0 = counter;
      s0 = n_step;
      f0 = n_flush;
      cyc(40);
      @(negedge i_clk);
      chk(counter, c0);
      chk(n_step - s0, 0);
      cyc(1);
      halt <= 1'b0;
      cyc(10);
      @(negedge i_clk);
      chk(n_flush - f0, 2);
      cyc(40);
      chk(counter === c0, 32'h0);
   endtask : scen_freeze
   initial
   begin
      cyc(3);
      i_sys_rst <= 1'b0;
      scen_reset();
      scen_flags();
      scen_inputs();
      scen_transfer();
      scen_filter();
      scen_prescale();
      scen_freeze();
      stop_test();
   end
   initial
   begin
      cyc(20000);
      error_cnt++;
      stop_test();
   end
endmodule : testbench
